// ==== src/ufb_baud_irq.sv ====
// How it works
// - one clock, clk_i, drives divider, prescaler and all internal logic.
// - prescaler divides input clock by 1 when select bit 0, by 4 when 1.
// - divisor divides prescaled clock by 1 up to 65536-1/16, sixteenth steps.
// - low and high divisor bytes form integer part, fraction register the rest.
// - only low four fraction bits exist; n means n/16.
// - reset sets divisor to one: low 0x01, high and fraction 0x00.
// - tx shifting and rx sampling both use the one sampling tick.
// - both selectors 0x00 gives 16x sampling.
// - eight-times selector 0xFF, four-times 0x00 gives 8x sampling.
// - four-times 0xFF, eight-times 0x00 gives 4x; both 0xFF reserved.
// - 8x mode with odd fraction may jitter bit time by 1/16.
// - fifo off: tx interrupt high while byte held, low when empty.
// - fifo on, no half duplex: high above trigger, else low.
// - fifo on, half duplex: also low when whole transmitter empty.
// - fifo on: rx interrupt high below trigger, low above it.
// - bit time lasts 16, 8 or 4 sampling periods by mode.
`timescale 1ns/1ns
`default_nettype none
module ufb_baud_irq
	import ufb_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// transmit side state
	input wire logic tx_holding_full_i,
	input wire logic tx_all_empty_i,
	input wire logic [LVL_W-1:0] tx_level_i,
	input wire logic [LVL_W-1:0] tx_trigger_i,
	// receive side state
	input wire logic [LVL_W-1:0] rx_level_i,
	input wire logic [LVL_W-1:0] rx_trigger_i,
	// timing pulses to shift registers
	output logic sample_tick_o,
	output logic bit_tick_o,
	// interrupt outputs
	output logic int_pin_o,
	output logic irq_o
);

	// software registers
	logic [7:0] div_low;
	logic [7:0] div_high;
	logic [FRAC_W-1:0] div_frac;
	logic [7:0] eight_sel;
	logic [7:0] four_sel;
	logic fifo_en;
	logic prescale_sel;
	logic half_duplex;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;

	// baud generator state
	logic [1:0] pre_cnt;
	logic [15:0] div_cnt;
	logic [FRAC_W-1:0] frac_acc;
	logic [4:0] samp_cnt;
	logic tx_cond_q;
	logic rx_cond_q;

	// bus decode
	wire bus_req = wb_cyc_i & wb_stb_i;
	wire wr_now = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	wire wr_low = wr_now & (wb_adr_i == ADR_DIV_LOW);
	wire wr_high = wr_now & (wb_adr_i == ADR_DIV_HIGH);
	wire wr_frac = wr_now & (wb_adr_i == ADR_DIV_FRAC);
	wire wr_eight = wr_now & (wb_adr_i == ADR_EIGHT_SEL);
	wire wr_four = wr_now & (wb_adr_i == ADR_FOUR_SEL);
	wire wr_queue = wr_now & (wb_adr_i == ADR_QUEUE_CTRL);
	wire wr_modem = wr_now & (wb_adr_i == ADR_MODEM_CTRL);
	wire wr_line = wr_now & (wb_adr_i == ADR_LINE_MODE);
	wire wr_istat = wr_now & (wb_adr_i == ADR_IRQ_STATUS);
	wire wr_imask = wr_now & (wb_adr_i == ADR_IRQ_MASK);
	// any change of rate restarts the generator so a shrinking divisor
	// never leaves the counter stranded above its new end value
	wire rate_wr = wr_low | wr_high | wr_frac | wr_eight | wr_four | wr_modem;

	// sampling mode decode; reserved and odd values fall back to 16x
	wire sel8 = (eight_sel == SEL_ON) & (four_sel == SEL_OFF);
	wire sel4 = (four_sel == SEL_ON) & (eight_sel == SEL_OFF);
	wire ufb_mode_t mode = sel8 ? UFB_MODE_8X :
		(sel4 ? UFB_MODE_4X : UFB_MODE_16X);

	// samples per bit from the mode
	logic [4:0] samples_per_bit;
	always_comb begin
		case (mode)
			UFB_MODE_16X: samples_per_bit = SAMPLES_16X;
			UFB_MODE_8X: samples_per_bit = SAMPLES_8X;
			UFB_MODE_4X: samples_per_bit = SAMPLES_4X;
			default: samples_per_bit = SAMPLES_16X;
		endcase
	end

	// prescaler: every clock, or every fourth clock
	wire pre_tick = ~prescale_sel | (pre_cnt == PRESCALE_LAST);

	// divisor: integer from both bytes, zero treated as one
	wire [15:0] div_int = {div_high, div_low};
	wire [15:0] div_eff = (div_int == 16'h0000) ? 16'h0001 : div_int;
	// fraction accumulator carry stretches a period by one prescaled tick
	wire [FRAC_W:0] acc_sum = {1'b0, frac_acc} + {1'b0, div_frac};
	wire frac_carry = acc_sum[FRAC_W];
	wire [16:0] period_last = {1'b0, div_eff} - 17'h0_0001
		+ {16'h0000, frac_carry};
	wire period_end = pre_tick & ({1'b0, div_cnt} == period_last);
	wire bit_end = period_end & (samp_cnt == samples_per_bit - 5'h01);

	// interrupt pin conditions from the transmitter and receiver
	wire tx_above = tx_level_i > tx_trigger_i;
	wire tx_cond_fifo = tx_above & ~(half_duplex & tx_all_empty_i);
	wire tx_cond = fifo_en ? tx_cond_fifo : tx_holding_full_i;
	wire rx_cond = fifo_en & (rx_level_i < rx_trigger_i);
	wire pin_cond = tx_cond | rx_cond;

	// events for the sticky status register
	wire [EV_W-1:0] ev_set = {bit_end, rx_cond & ~rx_cond_q,
		tx_cond & ~tx_cond_q};
	wire [EV_W-1:0] ev_clr = wr_istat ? wb_dat_i[EV_W-1:0] : RST_IRQ;
	// set wins over a clear in the same cycle
	wire [EV_W-1:0] next_irq_status = (irq_status & ~ev_clr) | ev_set;

	// read mux, unmapped addresses read zero
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			ADR_DIV_LOW: rd_data[7:0] = div_low;
			ADR_DIV_HIGH: rd_data[7:0] = div_high;
			ADR_DIV_FRAC: rd_data[FRAC_W-1:0] = div_frac;
			ADR_EIGHT_SEL: rd_data[7:0] = eight_sel;
			ADR_FOUR_SEL: rd_data[7:0] = four_sel;
			ADR_QUEUE_CTRL: rd_data[QC_FIFO_EN_BIT] = fifo_en;
			ADR_MODEM_CTRL: rd_data[MC_PRESCALE_BIT] = prescale_sel;
			ADR_LINE_MODE: rd_data[LM_HALF_DUPLEX_BIT] = half_duplex;
			ADR_STATE: rd_data[7:0] = {1'b0, mode, tx_cond_q, rx_cond_q,
				samp_cnt[2:0]};
			ADR_IRQ_STATUS: rd_data[EV_W-1:0] = irq_status;
			ADR_IRQ_MASK: rd_data[EV_W-1:0] = irq_mask;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// bus answer: ack one cycle after request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			wb_dat_o <= rd_data;
		end
	end

	// divisor registers, written at the acknowledging edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_low <= RST_DIV_LOW;
			div_high <= RST_DIV_HIGH;
			div_frac <= RST_DIV_FRAC[FRAC_W-1:0];
		end else begin
			if (wr_low)
				div_low <= wb_dat_i[7:0];
			if (wr_high)
				div_high <= wb_dat_i[7:0];
			if (wr_frac)
				div_frac <= wb_dat_i[FRAC_W-1:0];
		end
	end

	// mode and control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eight_sel <= RST_SAMPLE_SEL;
			four_sel <= RST_SAMPLE_SEL;
			fifo_en <= RST_CTRL[QC_FIFO_EN_BIT];
			prescale_sel <= RST_CTRL[MC_PRESCALE_BIT];
			half_duplex <= RST_CTRL[LM_HALF_DUPLEX_BIT];
		end else begin
			if (wr_eight)
				eight_sel <= wb_dat_i[7:0];
			if (wr_four)
				four_sel <= wb_dat_i[7:0];
			if (wr_queue)
				fifo_en <= wb_dat_i[QC_FIFO_EN_BIT];
			if (wr_modem)
				prescale_sel <= wb_dat_i[MC_PRESCALE_BIT];
			if (wr_line)
				half_duplex <= wb_dat_i[LM_HALF_DUPLEX_BIT];
		end
	end

	// interrupt status and mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= RST_IRQ;
			irq_mask <= RST_IRQ;
		end else begin
			irq_status <= next_irq_status;
			if (wr_imask)
				irq_mask <= wb_dat_i[EV_W-1:0];
		end
	end

	// prescaler counter on the single core clock, cleared by rate writes, held at zero when dividing by one
	always_ff @(posedge clk_i) begin
		if (rst_i | rate_wr | ~prescale_sel)
			pre_cnt <= 2'h0;
		else
			pre_cnt <= pre_cnt + 2'h1;
	end

	// divisor counter and fraction accumulator
	always_ff @(posedge clk_i) begin
		if (rst_i | rate_wr) begin
			div_cnt <= 16'h0000;
			frac_acc <= 4'h0;
		end else if (period_end) begin
			div_cnt <= 16'h0000;
			frac_acc <= acc_sum[FRAC_W-1:0];
		end else if (pre_tick) begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	// sampling periods per bit; in 8x an odd fraction cannot split
	// evenly over eight periods, so bit times alternate by 1/16
	always_ff @(posedge clk_i) begin
		if (rst_i | rate_wr)
			samp_cnt <= 5'h00;
		else if (bit_end)
			samp_cnt <= 5'h00;
		else if (period_end)
			samp_cnt <= samp_cnt + 5'h01;
	end

	// registered timing pulses shared by transmitter and receiver
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_tick_o <= 1'b0;
			bit_tick_o <= 1'b0;
		end else begin
			sample_tick_o <= period_end;
			bit_tick_o <= bit_end;
		end
	end

	// interrupt outputs, registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_cond_q <= 1'b0;
			rx_cond_q <= 1'b0;
			int_pin_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			tx_cond_q <= tx_cond;
			rx_cond_q <= rx_cond;
			int_pin_o <= pin_cond;
			irq_o <= |(next_irq_status & irq_mask);
		end
	end

endmodule : ufb_baud_irq
`default_nettype wire

// ==== pkg/ufb_pkg.sv ====
`default_nettype none
package ufb_pkg;
	// register byte addresses, one aligned word each
	localparam logic [7:0] ADR_DIV_LOW = 8'h00;
	localparam logic [7:0] ADR_DIV_HIGH = 8'h04;
	localparam logic [7:0] ADR_DIV_FRAC = 8'h08;
	localparam logic [7:0] ADR_EIGHT_SEL = 8'h0C;
	localparam logic [7:0] ADR_FOUR_SEL = 8'h10;
	localparam logic [7:0] ADR_QUEUE_CTRL = 8'h14;
	localparam logic [7:0] ADR_MODEM_CTRL = 8'h18;
	localparam logic [7:0] ADR_LINE_MODE = 8'h1C;
	localparam logic [7:0] ADR_STATE = 8'h20;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h24;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h28;

	// field positions
	localparam int QC_FIFO_EN_BIT = 0;
	localparam int MC_PRESCALE_BIT = 7;
	localparam int LM_HALF_DUPLEX_BIT = 0;
	localparam int FRAC_W = 4;
	localparam int EV_TX_BIT = 0;
	localparam int EV_RX_BIT = 1;
	localparam int EV_BIT_TIME = 2;
	localparam int EV_W = 3;

	// reset values
	localparam logic [7:0] RST_DIV_LOW = 8'h01;
	localparam logic [7:0] RST_DIV_HIGH = 8'h00;
	localparam logic [7:0] RST_DIV_FRAC = 8'h00;
	localparam logic [7:0] RST_SAMPLE_SEL = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [EV_W-1:0] RST_IRQ = 3'h0;

	// sampling mode selector values and counts
	localparam logic [7:0] SEL_ON = 8'hFF;
	localparam logic [7:0] SEL_OFF = 8'h00;
	localparam logic [4:0] SAMPLES_16X = 5'h10;
	localparam logic [4:0] SAMPLES_8X = 5'h08;
	localparam logic [4:0] SAMPLES_4X = 5'h04;
	localparam logic [1:0] PRESCALE_LAST = 2'h3; // divide by 4

	// timing
	localparam int CLK_FREQ_HZ = 10_000_000;

	// fifo level width (0..32 entries)
	localparam int LVL_W = 6;

	typedef enum logic [1:0] {
		UFB_MODE_16X = 2'b00,
		UFB_MODE_8X = 2'b01,
		UFB_MODE_4X = 2'b10
	} ufb_mode_t;
endpackage : ufb_pkg
`default_nettype wire

// ==== verification/ufb_baud_irq_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module ufb_baud_irq_asserts
	import ufb_pkg::*;
(
	// watched ports
	input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
	input wire logic tx_holding_full_i, tx_all_empty_i,
	input wire logic [LVL_W-1:0] tx_level_i, tx_trigger_i,
	input wire logic [LVL_W-1:0] rx_level_i, rx_trigger_i,
	input wire logic sample_tick_o, bit_tick_o, int_pin_o, irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus answers each request once, for one cycle
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("long ack");
	// outputs quiet after reset, ticks start at divisor one
	property p_rst; $fell(rst_i) |-> !wb_ack_o && !int_pin_o && !irq_o;
	endproperty
	a_rst: assert property (p_rst) else $error("busy after reset");
	property p_run; $fell(rst_i) |-> ##[0:3] sample_tick_o; endproperty
	a_run: assert property (p_run) else $error("no tick");
	// bit end lands on a sample, never closer than four cycles
	property p_bit; bit_tick_o |-> sample_tick_o; endproperty
	a_bit: assert property (p_bit) else $error("bit off tick");
	property p_gap; bit_tick_o |=> !bit_tick_o [*3]; endproperty
	a_gap: assert property (p_gap) else $error("bit too short");
	// pin follows queue state one edge later, whatever the mode
	property p_low; !tx_holding_full_i && tx_level_i <= tx_trigger_i
		&& rx_level_i >= rx_trigger_i |=> !int_pin_o; endproperty
	a_low: assert property (p_low) else $error("pin high");
	property p_high; tx_holding_full_i && tx_level_i > tx_trigger_i
		&& !tx_all_empty_i |=> int_pin_o; endproperty
	a_high: assert property (p_high) else $error("pin low");
endmodule : ufb_baud_irq_asserts
bind ufb_baud_irq ufb_baud_irq_asserts i_ufb_baud_irq_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .tx_holding_full_i(tx_holding_full_i),
	.tx_all_empty_i(tx_all_empty_i), .tx_level_i(tx_level_i),
	.tx_trigger_i(tx_trigger_i), .rx_level_i(rx_level_i),
	.rx_trigger_i(rx_trigger_i), .sample_tick_o(sample_tick_o),
	.bit_tick_o(bit_tick_o), .int_pin_o(int_pin_o), .irq_o(irq_o));
`default_nettype wire

// ==== verification/ufb_fifo_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ufb_fifo_model
	import ufb_pkg::*;
(
	// clock and enable
	input wire logic clk_i,
	input wire logic run_i,
	// queue state
	output logic full_o,
	output logic empty_o,
	output logic [LVL_W-1:0] tl_o,
	output logic [LVL_W-1:0] tt_o,
	output logic [LVL_W-1:0] rl_o,
	output logic [LVL_W-1:0] rt_o
);
	integer seed = 32'h2424;
	logic [31:0] r = 32'h0000_0000;
	// new state every cycle; a real queue can jump this fast too
	always @(posedge clk_i)
		r <= $random(seed);
	// idle: nothing held, transmitter drained, levels zero
	assign full_o = run_i & r[24];
	assign tl_o = run_i & ~r[26] ? {1'b0, r[4:0]} : '0;
	assign empty_o = tl_o == '0 && !full_o && (!run_i || r[25]);
	assign tt_o = run_i ? {1'b0, r[9:5]} : '0;
	assign rl_o = run_i ? {1'b0, r[14:10]} : '0;
	assign rt_o = run_i ? {1'b0, r[19:15]} : '0;
endmodule : ufb_fifo_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import ufb_pkg::*;
;
	logic clk_i, rst_i = 1, cyc = 0, stb = 0, we = 0, run = 0;
	logic ack, full, emp, stk, btk, pin, irq, e, fe, hd;
	logic [7:0] adr = 0;
	logic [31:0] wd = 0, rdat, rv, r;
	logic [LVL_W-1:0] tl, tt, rl, rt;
	integer seed = 32'h2424, failures = 0, checked = 0, cnt = 0;
	integer n, t0, d, f;
	localparam logic [7:0] ADRS [5] = '{ADR_DIV_LOW, ADR_DIV_HIGH,
		ADR_DIV_FRAC, ADR_EIGHT_SEL, ADR_FOUR_SEL};
	ufb_baud_irq i_ufb_baud_irq (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
		.tx_holding_full_i(full), .tx_all_empty_i(emp), .tx_level_i(tl),
		.tx_trigger_i(tt), .rx_level_i(rl), .rx_trigger_i(rt),
		.sample_tick_o(stk), .bit_tick_o(btk), .int_pin_o(pin), .irq_o(irq));
	ufb_fifo_model i_ufb_fifo_model (.clk_i(clk_i), .run_i(run),
		.full_o(full), .empty_o(emp), .tl_o(tl), .tt_o(tt), .rl_o(rl),
		.rt_o(rt));
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= v;
		repeat (50) if (ack !== 1'b1) @(posedge clk_i);
		rv = rdat;
		cyc <= 0;
		stb <= 0;
	endtask : bus
	// edge first, so a bit end just seen is not counted twice
	task automatic wbit;
		@(posedge clk_i);
		repeat (20000) if (btk !== 1'b1) @(posedge clk_i);
	endtask : wbit
	// whole carries per bit since the fraction suits the mode
	function automatic int exp_bit(int dv, int fv, int m, int p);
		return (p ? 4 : 1) * ((16 >> m) * dv + fv * (16 >> m) / 16);
	endfunction : exp_bit
	function automatic logic exp_int();
		return fe ? (tl > tt && !(hd && emp)) || rl < rt : full;
	endfunction : exp_int
	task automatic close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	// clock
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	// cycle count, also the hang guard
	always @(posedge clk_i) begin
		cnt <= cnt + 1;
		if (cnt == 60000) begin
			failures = failures + 1;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		// reset values, then random write and read back
		for (n = 0; n < 5; n++) begin
			bus(0, ADRS[n], 0);
			chk(rv, n == 0 ? 32'h0000_0001 : 32'h0000_0000);
			r = $random(seed);
			bus(1, ADRS[n], r);
			bus(0, ADRS[n], 0);
			chk(rv, r & (n == 2 ? 32'h0000_000F : 32'h0000_00FF));
		end
		$display("test registers done");
		// bit length for each mode and prescale
		for (n = 0; n < 6; n++) begin
			r = $random(seed);
			d = r[1:0] + 2;
			f = r[7:4] & (4'hF << n % 3);
			bus(1, ADR_MODEM_CTRL, 32'(n / 3) << MC_PRESCALE_BIT);
			bus(1, ADR_EIGHT_SEL, {24'h0, n % 3 == 1 ? SEL_ON : SEL_OFF});
			bus(1, ADR_FOUR_SEL, {24'h0, n % 3 == 2 ? SEL_ON : SEL_OFF});
			bus(1, ADR_DIV_HIGH, 32'h0000_0000);
			bus(1, ADR_DIV_FRAC, 32'(f));
			bus(1, ADR_DIV_LOW, 32'(d));
			wbit();
			wbit();
			t0 = cnt;
			wbit();
			chk(cnt - t0, exp_bit(d, f, n % 3, n / 3));
		end
		$display("test rates done");
		// pin against random queues: fifo off, on, half duplex
		run <= 1;
		for (n = 0; n < 3; n++) begin
			fe = n > 0;
			hd = n == 2;
			bus(1, ADR_QUEUE_CTRL, {31'h0, fe});
			bus(1, ADR_LINE_MODE, {31'h0, hd});
			repeat (60) begin
				@(posedge clk_i);
				#1;
				e = exp_int();
				@(posedge clk_i);
				#1;
				chk({31'h0, pin}, {31'h0, e});
			end
		end
		// both queue events must have latched while the pin moved
		bus(0, ADR_IRQ_STATUS, 0);
		chk({30'h0, rv[1:0]}, 32'h0000_0003);
		$display("test pin done");
		// long divisor keeps new bit events out while clearing
		run <= 0;
		bus(1, ADR_DIV_HIGH, 32'h0000_0001);
		bus(1, ADR_IRQ_STATUS, 32'h0000_0007);
		bus(1, ADR_IRQ_MASK, 32'h0000_0004);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0000_0000);
		wbit();
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0000_0001);
		bus(1, ADR_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0000_0000);
		$display("test irq done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
